// [core/iwc_core.sv]
// Interrupt and wake control register with its serial port and the
// transceiver, wake input and wake bias control that it steers.
// Assumes all pins asynchronous to mclk; chipMode and biasRate come from mclk logic.
`timescale 1ns/1ps
`include "iwc_defs.svh"

module iwc_core #(
  parameter int SHORT_CYC  = `IWC_SHORT_MS * (`IWC_CLK_HZ / 1000),
  parameter int LONG_CYC   = `IWC_LONG_MS * (`IWC_CLK_HZ / 1000),
  parameter int BIAS_ON_CYC = `IWC_BIAS_ON_US * (`IWC_CLK_HZ / 1000000)
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             sck,
  input  wire logic             scsN,
  input  wire logic             sdi,
  output logic                  sdo,
  output logic                  sdoOe,
  input  wire iwc_pkg::iwc_mode_e chipMode,
  input  wire logic             biasRate,
  input  wire logic             mainUvWarn,
  input  wire logic             xcvrUvWarn,
  input  wire logic             linAWakeDet,
  input  wire logic             linBWakeDet,
  input  wire logic             canWakeDet,
  input  wire logic             wakeInputA,
  input  wire logic             wakeInputB,
  output iwc_pkg::iwc_irq_s     irqReq,
  output iwc_pkg::iwc_xcvr_s    linACtrl,
  output iwc_pkg::iwc_xcvr_s    linBCtrl,
  output iwc_pkg::iwc_xcvr_s    canCtrl,
  output logic                  resetLevelSel,
  output logic                  wakeBiasOutput,
  output logic                  wakeBiasOe
);

  // ========================================================
  // Functions
  function automatic iwc_pkg::iwc_xcvr_s xcvrDecode(
    input logic               standby,
    input iwc_pkg::iwc_mode_e mode
  );
    iwc_pkg::iwc_xcvr_s r;
    r = '0;
    if (standby)
    begin
      r.state     = iwc_pkg::IWC_X_LOWPWR;
      r.wakeDetEn = 1'b1;
      r.wakeIrqEn = 1'b1;
    end
    else if (mode == iwc_pkg::IWC_NORMAL_V2OFF ||
             mode == iwc_pkg::IWC_NORMAL_V2ON)
    begin
      r.state       = iwc_pkg::IWC_X_ACTIVE;
      r.wakeFlagClr = 1'b1;
    end
    else
    begin
      r.state = iwc_pkg::IWC_X_OFF;
    end
    return r;
  endfunction : xcvrDecode

  function automatic logic edgeHit(
    input logic [1:0] sel,
    input logic       cur,
    input logic       prev
  );
    // Code 11 takes both edges on either input
    return (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
  endfunction : edgeHit

  // ========================================================
  // Pin synchronisers; stage three only feeds edge detection
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] syncA;
  logic [NSYNC-1:0] syncB;
  logic [NSYNC-1:0] syncC;
  logic [NSYNC-1:0] pinIn;

  assign pinIn = {sck, scsN, sdi, mainUvWarn, xcvrUvWarn,
                  linAWakeDet, linBWakeDet, canWakeDet,
                  wakeInputA, wakeInputB};

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA <= 10'h3FF;
      syncB <= 10'h3FF;
      syncC <= 10'h3FF;
    end
    else
    begin
      syncA <= pinIn;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  logic sckNow;
  logic sckOld;
  logic csNow;
  logic csOld;
  logic sdiNow;
  assign sckNow = syncB[9];
  assign sckOld = syncC[9];
  assign csNow  = syncB[8];
  assign csOld  = syncC[8];
  assign sdiNow = syncB[7];

  // ========================================================
  // Serial frame engine and control register
  iwc_pkg::iwc_spi_e spiState;
  iwc_pkg::iwc_spi_e next_spiState;
  logic [15:0] rxShift;
  logic [15:0] next_rxShift;
  logic [15:0] txShift;
  logic [15:0] next_txShift;
  logic [4:0]  bitCnt;
  logic [4:0]  next_bitCnt;
  logic [11:0] ctrl;
  logic [11:0] next_ctrl;
  logic        next_sdo;
  logic        next_sdoOe;

  always_comb
  begin
    next_spiState = spiState;
    next_rxShift  = rxShift;
    next_txShift  = txShift;
    next_bitCnt   = bitCnt;
    next_ctrl     = ctrl;
    next_sdo      = sdo;
    next_sdoOe    = sdoOe;
    case (spiState)
      iwc_pkg::IWC_SPI_IDLE:
      begin
        next_sdoOe = 1'b0;
        next_sdo   = 1'b0;
        if (!csNow && csOld)
        begin
          next_spiState = iwc_pkg::IWC_SPI_SHIFT;
          // Address code leads, lock reads zero
          next_txShift  = {`IWC_REG_ADDR, 1'b0, ctrl};
          next_sdo      = 1'(`IWC_REG_ADDR >> 2);
          next_sdoOe    = 1'b1;
          next_bitCnt   = 5'h00;
        end
      end
      iwc_pkg::IWC_SPI_SHIFT:
      begin
        if (csNow)
        begin
          next_spiState = iwc_pkg::IWC_SPI_IDLE;
          next_sdoOe    = 1'b0;
          // Only a whole frame for this address may write
          if (bitCnt == `IWC_FRAME_BITS &&
              rxShift[`IWC_ADDR_MSB:`IWC_ADDR_LSB] == `IWC_REG_ADDR &&
              !rxShift[`IWC_LOCK_BIT])
            next_ctrl = rxShift[11:0];
        end
        else
        begin
          if (sckNow && !sckOld && bitCnt != 5'h00)
          begin
            next_txShift = {txShift[14:0], 1'b0};
            next_sdo     = txShift[14];
          end
          if (!sckNow && sckOld)
          begin
            next_rxShift = {rxShift[14:0], sdiNow};
            if (bitCnt != `IWC_CNT_SAT)
              next_bitCnt = bitCnt + 5'h01;
          end
        end
      end
      default:
      begin
        next_spiState = iwc_pkg::IWC_SPI_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spiState <= iwc_pkg::IWC_SPI_IDLE;
      rxShift  <= 16'h0000;
      txShift  <= 16'h0000;
      bitCnt   <= 5'h00;
      ctrl     <= `IWC_CTRL_RESET;
      sdo      <= 1'b0;
      sdoOe    <= 1'b0;
    end
    else
    begin
      spiState <= next_spiState;
      rxShift  <= next_rxShift;
      txShift  <= next_txShift;
      bitCnt   <= next_bitCnt;
      ctrl     <= next_ctrl;
      sdo      <= next_sdo;
      sdoOe    <= next_sdoOe;
    end
  end

  // ========================================================
  // Wake bias timer and wake input sampling
  logic [`IWC_TMR_W-1:0] biasTmr;
  logic [`IWC_TMR_W-1:0] next_biasTmr;
  logic                  sampleTick;
  logic                  biasWindow;
  logic                  strobeAny;
  logic                  heldA;
  logic                  heldB;
  logic                  prevA;
  logic                  prevB;
  logic                  next_heldA;
  logic                  next_heldB;
  logic                  next_biasOut;
  logic                  next_biasOe;

  assign strobeAny  = ctrl[`IWC_WKA_STR_BIT] | ctrl[`IWC_WKB_STR_BIT];

  always_comb
  begin
    logic [`IWC_TMR_W-1:0] last;
    last = `IWC_TMR_W'(SHORT_CYC - 1);
    if (biasRate)
      last = `IWC_TMR_W'(LONG_CYC - 1);
    next_biasTmr = (biasTmr >= last) ? '0 : biasTmr + 1'b1;
    biasWindow   = biasTmr < `IWC_TMR_W'(BIAS_ON_CYC);
    sampleTick   = biasTmr == `IWC_TMR_W'(BIAS_ON_CYC - 1);
    // Strobed inputs only change at the end of a bias pulse
    next_heldA = ctrl[`IWC_WKA_STR_BIT] ?
                 (sampleTick ? syncB[1] : heldA) : syncB[1];
    next_heldB = ctrl[`IWC_WKB_STR_BIT] ?
                 (sampleTick ? syncB[0] : heldB) : syncB[0];
    if (strobeAny)
    begin
      next_biasOut = biasWindow;
      next_biasOe  = biasWindow;
    end
    else
    begin
      next_biasOut = biasRate;
      next_biasOe  = biasRate;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      biasTmr        <= '0;
      heldA          <= 1'b1;
      heldB          <= 1'b1;
      prevA          <= 1'b1;
      prevB          <= 1'b1;
      wakeBiasOutput <= 1'b0;
      wakeBiasOe     <= 1'b0;
    end
    else
    begin
      biasTmr        <= next_biasTmr;
      heldA          <= next_heldA;
      heldB          <= next_heldB;
      prevA          <= heldA;
      prevB          <= heldB;
      wakeBiasOutput <= next_biasOut;
      wakeBiasOe     <= next_biasOe;
    end
  end

  // ========================================================
  // Outputs: transceiver control, requests, reset level
  iwc_pkg::iwc_xcvr_s next_linA;
  iwc_pkg::iwc_xcvr_s next_linB;
  iwc_pkg::iwc_xcvr_s next_can;
  iwc_pkg::iwc_irq_s  next_irq;

  always_comb
  begin
    next_linA = xcvrDecode(ctrl[`IWC_LINA_SB_BIT], chipMode);
    next_linB = xcvrDecode(ctrl[`IWC_LINB_SB_BIT], chipMode);
    next_can  = xcvrDecode(ctrl[`IWC_CAN_SB_BIT], chipMode);
    next_irq  = '0;
    next_irq.mainUv   = ctrl[`IWC_MAIN_IE_BIT] &
                        syncB[6] & ~syncC[6];
    next_irq.xcvrUv   = ctrl[`IWC_XCVR_IE_BIT] &
                        syncB[5] & ~syncC[5];
    next_irq.linAWake = next_linA.wakeIrqEn & syncB[4] & ~syncC[4];
    next_irq.linBWake = next_linB.wakeIrqEn & syncB[3] & ~syncC[3];
    next_irq.canWake  = next_can.wakeIrqEn & syncB[2] & ~syncC[2];
    next_irq.wakeA    = edgeHit(ctrl[`IWC_WKA_HI_BIT:`IWC_WKA_LO_BIT],
                                heldA, prevA);
    next_irq.wakeB    = edgeHit(ctrl[`IWC_WKB_HI_BIT:`IWC_WKB_LO_BIT],
                                heldB, prevB);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      linACtrl      <= '0;
      linBCtrl      <= '0;
      canCtrl       <= '0;
      irqReq        <= '0;
      resetLevelSel <= 1'b0;
    end
    else
    begin
      linACtrl      <= next_linA;
      linBCtrl      <= next_linB;
      canCtrl       <= next_can;
      irqReq        <= next_irq;
      resetLevelSel <= ctrl[`IWC_RST_LVL_BIT];
    end
  end

endmodule : iwc_core

// [pkg/iwc_defs.svh]
// Constants of the interrupt and wake control register block.
// Assumes inclusion by bare name from the core file only.
`ifndef IWC_DEFS_SVH
`define IWC_DEFS_SVH

// ==========================================================
// Register layout
`define IWC_REG_ADDR     3'h2
`define IWC_ADDR_MSB     15
`define IWC_ADDR_LSB     13
`define IWC_LOCK_BIT     12
`define IWC_MAIN_IE_BIT  11
`define IWC_XCVR_IE_BIT  10
`define IWC_LINA_SB_BIT  9
`define IWC_LINB_SB_BIT  8
`define IWC_WKA_HI_BIT   7
`define IWC_WKA_LO_BIT   6
`define IWC_WKB_HI_BIT   5
`define IWC_WKB_LO_BIT   4
`define IWC_CAN_SB_BIT   3
`define IWC_RST_LVL_BIT  2
`define IWC_WKA_STR_BIT  1
`define IWC_WKB_STR_BIT  0
`define IWC_CTRL_RESET   12'h000
`define IWC_FRAME_BITS   5'h10
`define IWC_CNT_SAT      5'h1F

// ==========================================================
// Timing
`define IWC_CLK_HZ       50000000
`define IWC_SHORT_MS     16
`define IWC_LONG_MS      64
`define IWC_BIAS_ON_US   100
`define IWC_TMR_W        22

`endif

// [pkg/iwc_pkg.sv]
// Types shared by the interrupt and wake control block.
// Assumes nothing beyond a SystemVerilog compiler.
package iwc_pkg;

  // ========================================================
  // Chip operating mode as driven by the mode register
  typedef enum logic [1:0]
  {
    IWC_STANDBY      = 2'b00,
    IWC_SLEEP        = 2'b01,
    IWC_NORMAL_V2OFF = 2'b10,
    IWC_NORMAL_V2ON  = 2'b11
  } iwc_mode_e;

  // ========================================================
  // Transceiver state
  typedef enum logic [1:0]
  {
    IWC_X_OFF    = 2'b00,
    IWC_X_ACTIVE = 2'b01,
    IWC_X_LOWPWR = 2'b10
  } iwc_xstate_e;

  typedef struct packed
  {
    iwc_xstate_e state;
    logic        wakeDetEn;
    logic        wakeIrqEn;
    logic        wakeFlagClr;
  } iwc_xcvr_s;

  // ========================================================
  // Interrupt request pulses
  typedef struct packed
  {
    logic mainUv;
    logic xcvrUv;
    logic linAWake;
    logic linBWake;
    logic canWake;
    logic wakeA;
    logic wakeB;
  } iwc_irq_s;

  // ========================================================
  // Serial frame state
  typedef enum logic [0:0]
  {
    IWC_SPI_IDLE  = 1'b0,
    IWC_SPI_SHIFT = 1'b1
  } iwc_spi_e;

endpackage : iwc_pkg

// [verif/iwc_core_assertions.sv]
// Checker on the transceiver control and request outputs.
// Assumes a bind into iwc_core; single mclk domain.
`timescale 1ns/1ps
module iwc_core_assertions (
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire iwc_pkg::iwc_mode_e chipMode,
  input wire iwc_pkg::iwc_irq_s  irqReq,
  input wire iwc_pkg::iwc_xcvr_s linACtrl,
  input wire iwc_pkg::iwc_xcvr_s linBCtrl,
  input wire iwc_pkg::iwc_xcvr_s canCtrl,
  input wire logic               scsN,
  input wire logic               sdoOe
);
  // ========================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_lina_off_quiet: assert property (
    linACtrl.state == iwc_pkg::IWC_X_OFF
    |-> !linACtrl.wakeDetEn && !linACtrl.wakeIrqEn)
    else $error("LIN A off awake");
  // Mode is decoded in a single register stage
  a_lina_active_normal: assert property (
    linACtrl.state == iwc_pkg::IWC_X_ACTIVE
    |-> linACtrl.wakeFlagClr && $past(chipMode[1]))
    else $error("LIN A active outside normal");
  a_lina_low_wake: assert property (
    linACtrl.state == iwc_pkg::IWC_X_LOWPWR
    |-> linACtrl.wakeDetEn && linACtrl.wakeIrqEn)
    else $error("LIN A low no wake");
  a_linb_off_quiet: assert property (
    linBCtrl.state == iwc_pkg::IWC_X_OFF
    |-> !linBCtrl.wakeDetEn && !linBCtrl.wakeIrqEn)
    else $error("LIN B off awake");
  a_can_off_quiet: assert property (
    canCtrl.state == iwc_pkg::IWC_X_OFF
    |-> !canCtrl.wakeDetEn && !canCtrl.wakeIrqEn)
    else $error("CAN off awake");
  a_can_low_wake: assert property (
    canCtrl.state == iwc_pkg::IWC_X_LOWPWR
    |-> canCtrl.wakeDetEn && canCtrl.wakeIrqEn)
    else $error("CAN low no wake");
  // Request and control leave the same register stage
  a_lina_irq_gate: assert property (
    irqReq.linAWake |-> linACtrl.wakeIrqEn)
    else $error("LIN A request while gated");
  a_can_irq_gate: assert property (
    irqReq.canWake |-> canCtrl.wakeIrqEn)
    else $error("CAN request while gated");
  a_uv_one_pulse: assert property (
    irqReq.mainUv |=> !irqReq.mainUv)
    else $error("Main warning request too long");
  // Output enable belongs to a selected frame only
  a_oe_in_frame: assert property (
    $rose(sdoOe) |-> !scsN)
    else $error("Serial output enabled outside a frame");
  a_oe_release: assert property (
    $fell(sdoOe) |-> scsN)
    else $error("Serial output released inside a frame");
  c_lina_low: cover property (linACtrl.state == iwc_pkg::IWC_X_LOWPWR);
  c_wake_a: cover property (irqReq.wakeA);
  c_main_uv: cover property (irqReq.mainUv);
  c_frame: cover property ($rose(sdoOe));
endmodule : iwc_core_assertions

bind iwc_core iwc_core_assertions i_iwc_core_assertions (.mclk(mclk),
  .rst_n(rst_n), .chipMode(chipMode), .irqReq(irqReq),
  .linACtrl(linACtrl), .linBCtrl(linBCtrl), .canCtrl(canCtrl),
  .scsN(scsN), .sdoOe(sdoOe));

// [verif/iwc_core_tb_top.sv]
// Bench for the interrupt and wake control register block.
// Assumes short bias timing through the core parameters.
`timescale 1ns/1ps
module iwc_core_tb_top;
  logic               mclk;
  logic               rst_n;
  logic               sck;
  logic               scsN;
  logic               sdi;
  logic               sdo;
  logic               sdoOe;
  logic               sdoLine;
  logic               biasRate;
  iwc_pkg::iwc_mode_e chipMode;
  logic [6:0]         evIn;
  logic [6:0]         irqV;
  iwc_pkg::iwc_irq_s  irqReq;
  iwc_pkg::iwc_xcvr_s linACtrl;
  iwc_pkg::iwc_xcvr_s linBCtrl;
  iwc_pkg::iwc_xcvr_s canCtrl;
  logic               resetLevelSel;
  logic               wakeBiasOutput;
  logic               wakeBiasOe;
  logic [15:0]        rx;
  int                 failures;
  int                 cmp_count;
  assign irqV = irqReq;
  // Released line reads inverted, so a dropped enable shows up
  assign sdoLine = sdoOe ? sdo : ~sdo;
  localparam int SHORT_T = 64;
  localparam int LONG_T  = 128;
  // ========================================
  // Instances
  iwc_core #(.SHORT_CYC(SHORT_T), .LONG_CYC(LONG_T), .BIAS_ON_CYC(8))
    i_iwc_core (
    .mclk(mclk), .rst_n(rst_n), .sck(sck), .scsN(scsN), .sdi(sdi),
    .sdo(sdo), .sdoOe(sdoOe), .chipMode(chipMode), .biasRate(biasRate),
    .mainUvWarn(evIn[6]), .xcvrUvWarn(evIn[5]), .linAWakeDet(evIn[4]),
    .linBWakeDet(evIn[3]), .canWakeDet(evIn[2]), .wakeInputA(evIn[1]),
    .wakeInputB(evIn[0]), .irqReq(irqReq), .linACtrl(linACtrl),
    .linBCtrl(linBCtrl), .canCtrl(canCtrl), .resetLevelSel(resetLevelSel),
    .wakeBiasOutput(wakeBiasOutput), .wakeBiasOe(wakeBiasOe));
  iwc_host_model i_iwc_host_model (.mclk(mclk), .sdo(sdoLine), .sck(sck),
    .scsN(scsN), .sdi(sdi));
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ========================================
  // Helpers
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(logic [11:0] c);
    i_iwc_host_model.xfer({3'b010, 1'b0, c}, 16, rx);
  endtask : wr
  // Bit 12 set: frame is a pure read
  task automatic rd_chk(logic [11:0] c);
    i_iwc_host_model.xfer(16'h5000, 16, rx);
    chk("read word", {4'h4, c}, rx);
    chk("sdo enable idle", 16'h0, sdoOe);
  endtask : rd_chk
  task automatic toggle(int k, output int n);
    // Requests are pulses; count the cycles with the request high over 12 clocks
    @(negedge mclk);
    evIn[k] = ~evIn[k];
    n = 0;
    repeat (12)
    begin
      @(posedge mclk);
      #1 if (irqV[k] === 1'b1) n++;
    end
  endtask : toggle
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // ========================================
  // Scenarios
  task automatic t_access();
    rd_chk(12'h000);
    chk("lin a off", iwc_pkg::IWC_X_OFF, linACtrl.state);
    wr(12'h804);
    rd_chk(12'h804);
    chk("reset level", 16'h1, resetLevelSel);
    i_iwc_host_model.xfer(16'hE000, 16, rx);
    i_iwc_host_model.xfer(16'h4000, 15, rx);
    rd_chk(12'h804);
    wr(12'h000);
    chk("reset level", 16'h0, resetLevelSel);
    wr(12'h804);
    // Reset in mid-run brings back the power-on value
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    chk("reset level", 16'h0, resetLevelSel);
    rd_chk(12'h000);
  endtask : t_access
  task automatic t_modes();
    logic [1:0] e;
    for (int m = 0; m < 4; m++)
      for (int s = 0; s < 2; s++)
      begin
        chipMode = iwc_pkg::iwc_mode_e'(m[1:0]);
        wr(s[0] ? 12'h308 : 12'h000);
        e = s[0] ? 2'h2 : (m[1] ? 2'h1 : 2'h0);
        chk("lin a state", e, linACtrl.state);
        chk("lin b state", e, linBCtrl.state);
        chk("can state", e, canCtrl.state);
        chk("flag clear", e == 2'h1, canCtrl.wakeFlagClr);
        chk("lin a flag", e == 2'h1, linACtrl.wakeFlagClr);
      end
    chipMode = iwc_pkg::IWC_STANDBY;
  endtask : t_modes
  task automatic t_events();
    int n;
    for (int s = 0; s < 2; s++)
    begin
      wr(s[0] ? 12'hF08 : 12'h000);
      for (int k = 2; k < 7; k++)
      begin
        toggle(k, n);
        chk("event request", s, n);
        toggle(k, n);
      end
    end
  endtask : t_events
  task automatic t_wake_edges();
    int nf;
    int nr;
    for (int c = 0; c < 4; c++)
    begin
      wr({4'h0, c[1:0], c[1:0], 4'h0});
      for (int k = 0; k < 2; k++)
      begin
        toggle(k, nf);
        toggle(k, nr);
        chk("fall request", c[1], nf);
        chk("rise request", c[0], nr);
      end
    end
  endtask : t_wake_edges
  task automatic bias_period(int exp);
    int t0;
    int t1;
    logic b;
    logic pb;
    t0 = -1;
    t1 = -1;
    pb = 1'b1;
    for (int i = 0; i < 400; i++)
    begin
      @(posedge mclk);
      #1 b = wakeBiasOutput & wakeBiasOe;
      if (b === 1'b1 && pb === 1'b0)
      begin
        if (t0 < 0)
          t0 = i;
        else if (t1 < 0)
          t1 = i;
      end
      pb = b;
    end
    chk("bias period", 16'(exp), 16'(t1 - t0));
    @(negedge mclk);
  endtask : bias_period
  task automatic t_bias();
    wr(12'h002);
    bias_period(SHORT_T);
    biasRate = 1'b1;
    bias_period(LONG_T);
    wr(12'h000);
    chk("bias held on", 16'h3, {wakeBiasOutput, wakeBiasOe});
    biasRate = 1'b0;
    repeat (4) @(negedge mclk);
    chk("bias floating", 16'h0, wakeBiasOe);
  endtask : t_bias
  // Strobed input must wait for the end of a bias pulse
  task automatic t_strobe();
    int w;
    int n0;
    int n1;
    logic pb;
    pb = 1'b1;
    w  = 0;
    wr(12'h0C3);
    while (w < 400)
    begin
      @(posedge mclk);
      #1 if (wakeBiasOutput === 1'b1 && pb === 1'b0) break;
      pb = wakeBiasOutput;
      w++;
    end
    chk("bias pulse seen", 16'h1, w < 400);
    @(negedge mclk);
    evIn[1] = 1'b0;
    n0 = 0;
    repeat (5)
    begin
      @(posedge mclk);
      #1 if (irqV[1] === 1'b1) n0++;
    end
    n1 = 0;
    repeat (12)
    begin
      @(posedge mclk);
      #1 if (irqV[1] === 1'b1) n1++;
    end
    chk("strobe early", 16'h0, n0);
    chk("strobe late", 16'h1, n1);
    @(negedge mclk);
    evIn[1] = 1'b1;
    wr(12'h000);
  endtask : t_strobe
  // ========================================
  // Main sequence
  initial
  begin
    failures  = 0;
    cmp_count = 0;
    rst_n     = 1'b0;
    chipMode  = iwc_pkg::IWC_STANDBY;
    biasRate  = 1'b0;
    evIn      = 7'h03;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    t_access();
    t_modes();
    t_events();
    t_wake_edges();
    t_bias();
    t_strobe();
    report_and_stop();
  end
  // Cuts a hang short
  initial
  begin
    #1500000;
    failures++;
    report_and_stop();
  end
endmodule : iwc_core_tb_top

// [verif/iwc_host_model.sv]
// Host side serial master, clock polarity 0, MSB first.
// Assumes mclk of the block; signals change on its falling edge.
`timescale 1ns/1ps
module iwc_host_model (
  input  wire logic mclk,
  input  wire logic sdo,
  output logic      sck,
  output logic      scsN,
  output logic      sdi
);
  // ========================================
  // Frame driver
  initial
  begin
    sck  = 1'b0;
    scsN = 1'b1;
    sdi  = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, input int nb,
                      output logic [15:0] rx);
    rx   = 16'h0000;
    scsN = 1'b0;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < nb; i++)
    begin
      sdi = tx[15 - i];
      repeat (4) @(negedge mclk);
      sck = 1'b1;
      repeat (4) @(negedge mclk);
      rx  = {rx[14:0], sdo};
      sck = 1'b0;
      // Hold data past the sampled fall
      repeat (4) @(negedge mclk);
    end
    scsN = 1'b1;
    sdi  = ~sdi;
    repeat (8) @(negedge mclk);
  endtask : xfer
endmodule : iwc_host_model
